// >>> shared/sts3_sync_pkg.sv
// Shared constants and state types for the line frame synchronizer.
package sts3_sync_pkg;

  // Line bit timing: one unit interval is one line bit.
  localparam int UI_PS           = 6430;
  localparam int BYTE_BITS       = 8;
  localparam int BIT_CNT_W       = 3;
  localparam int TERM_CLK_BIT    = 2;

  // Frame geometry in terminal byte slots.
  localparam int FRAME_BYTES     = 2430;
  localparam int BYTE_CNT_W      = 12;
  localparam int B1_BYTE_INDEX   = 270;
  localparam int MAX_ERR_PULSES  = 8;

  // Receive path: line pin to terminal bus, in unit intervals.
  localparam int RX_LATENCY_UI   = 54;
  localparam int RX_PIPE_UI      = 11;
  localparam int RX_DELAY_STAGES = RX_LATENCY_UI - RX_PIPE_UI;

  // Transmit path: FIFO head to serial line pin, in unit intervals.
  localparam int TX_LATENCY_UI   = 44;
  localparam int TX_PIPE_UI      = 1;
  localparam int TX_DELAY_STAGES = TX_LATENCY_UI - TX_PIPE_UI;

  // Reference divider phases for the transmit reference clock.
  localparam logic [BIT_CNT_W-1:0] REF_RISE_PHASE = 3'h0;
  localparam logic [BIT_CNT_W-1:0] REF_FALL_PHASE = 3'h4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT       = 3'h7;

  // Frame synchronous descrambler seed, polynomial x^7 + x^6 + 1.
  localparam logic [6:0] SCR_SEED = 7'h7f;

  // Transmit buffer shape.
  localparam int FIFO_WIDTH      = 8;
  localparam int FIFO_DEPTH      = 8;

  typedef enum logic [1:0] {
    RX_WAIT_SEARCH = 2'b00,
    RX_ALIGNED     = 2'b01
  } rx_state_t;

endpackage

// >>> rtl/sync_two_flop.sv
// Two flip-flop level synchroniser with a constant reset value.
`timescale 1ns/1ps
module sync_two_flop #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= RESET_VAL;
      q_o  <= RESET_VAL;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule

// >>> rtl/stream_fifo.sv
// Valid/ready FIFO with a registered ready on the filling side.
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;
  logic             next_in_ready;
  logic             push;
  logic             pop;

  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_comb begin
    // Ready is registered, so it already reflects a full buffer one cycle early enough.
    push          = ce_i && in_valid_i && in_ready_o;
    pop           = ce_i && out_ready_i && out_valid_o;
    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    next_count    = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    next_in_ready = (next_count != FULL_CNT);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      in_ready_o <= next_in_ready;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

// >>> rtl/sts3_sync_init_and_los_handling.sv
// Line frame synchronizer core: receive deserializer, parity pulses, transmit reference and serializer.
`timescale 1ns/1ps

// What this block does
// - Without descrambling on signal loss the terminal bus follows the static line level.
// - With descrambling on signal loss the bus shows descrambler output, never a forced pattern.
// - No substitute clock ever drives the receive terminal side when the line clock dies.
// - Without line clock, terminal clock and data stop and the data bus holds.
// - The first line bit of a byte reaches the receive terminal bus exactly 54 unit intervals later.
// - A transmit byte reaches the serial line output exactly 44 unit intervals later.
// - One parity pulse per wrong parity bit, on falling terminal clock, eight per frame maximum.
// - Reference clock restarts after reset; frame changes on falling edge if inverted, else rising.
module sts3_sync_init_and_los_handling
  import sts3_sync_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  ce_i,
  input  wire logic                  rx_line_clock_i,
  input  wire logic                  rx_line_data_true_i,
  input  wire logic                  rx_line_data_comp_i,
  input  wire logic                  descrambler_select_i,
  input  wire logic                  frame_search_trigger_n_i,
  input  wire logic                  tx_ref_edge_invert_i,
  input  wire logic [FIFO_WIDTH-1:0] tx_terminal_data_i,
  input  wire logic                  tx_terminal_valid_i,
  output logic                       tx_terminal_ready_o,
  output logic      [BYTE_BITS-1:0]  rx_terminal_data_o,
  output logic                       rx_terminal_clock_o,
  output logic                       rx_reference_frame_o,
  output logic                       parity_error_pulse_o,
  output logic                       tx_line_data_true_o,
  output logic                       tx_line_data_comp_o,
  output logic                       tx_reference_clock_o,
  output logic                       tx_reference_frame_o
);

  // ---------------------------------------------------------------------------
  // Receive side: everything here runs on the recovered line clock only.
  // ---------------------------------------------------------------------------
  logic line_reset_n;
  logic line_ce;
  logic line_true;
  logic line_comp;
  logic line_descr_sel;
  logic line_search_n;

  // Reset release is brought into the line domain; assertion stays asynchronous.
  sync_two_flop #(.RESET_VAL(1'b0)) u_line_rst (
    .clk_i     (rx_line_clock_i),
    .reset_n_i (reset_n_i),
    .d_i       (1'b1),
    .q_o       (line_reset_n)
  );

  sync_two_flop #(.RESET_VAL(1'b0)) u_line_ce (
    .clk_i     (rx_line_clock_i),
    .reset_n_i (line_reset_n),
    .d_i       (ce_i),
    .q_o       (line_ce)
  );

  sync_two_flop #(.RESET_VAL(1'b0)) u_line_true (
    .clk_i     (rx_line_clock_i),
    .reset_n_i (line_reset_n),
    .d_i       (rx_line_data_true_i),
    .q_o       (line_true)
  );

  sync_two_flop #(.RESET_VAL(1'b1)) u_line_comp (
    .clk_i     (rx_line_clock_i),
    .reset_n_i (line_reset_n),
    .d_i       (rx_line_data_comp_i),
    .q_o       (line_comp)
  );

  sync_two_flop #(.RESET_VAL(1'b0)) u_line_descr (
    .clk_i     (rx_line_clock_i),
    .reset_n_i (line_reset_n),
    .d_i       (descrambler_select_i),
    .q_o       (line_descr_sel)
  );

  sync_two_flop #(.RESET_VAL(1'b1)) u_line_search (
    .clk_i     (rx_line_clock_i),
    .reset_n_i (line_reset_n),
    .d_i       (frame_search_trigger_n_i),
    .q_o       (line_search_n)
  );

  rx_state_t                    rx_state;
  rx_state_t                    next_rx_state;
  logic                         line_bit;
  logic                         next_line_bit;
  logic [RX_DELAY_STAGES-1:0]   rx_delay;
  logic [RX_DELAY_STAGES-1:0]   next_rx_delay;
  logic                         descr_bit;
  logic                         next_descr_bit;
  logic                         raw_bit;
  logic                         next_raw_bit;
  logic [6:0]                   scr;
  logic [6:0]                   next_scr;
  logic [BYTE_BITS-2:0]         descr_shift;
  logic [BYTE_BITS-2:0]         next_descr_shift;
  logic [BYTE_BITS-2:0]         raw_shift;
  logic [BYTE_BITS-2:0]         next_raw_shift;
  logic [BIT_CNT_W-1:0]         bit_cnt;
  logic [BIT_CNT_W-1:0]         next_bit_cnt;
  logic [BYTE_CNT_W-1:0]        byte_cnt;
  logic [BYTE_CNT_W-1:0]        next_byte_cnt;
  logic [BYTE_BITS-1:0]         bip_acc;
  logic [BYTE_BITS-1:0]         next_bip_acc;
  logic [BYTE_BITS-1:0]         bip_prev;
  logic [BYTE_BITS-1:0]         next_bip_prev;
  logic                         bip_valid;
  logic                         next_bip_valid;
  logic [MAX_ERR_PULSES-1:0]    err_pend;
  logic [MAX_ERR_PULSES-1:0]    next_err_pend;
  logic                         search_n_d;
  logic                         next_search_n_d;
  logic [BYTE_BITS-1:0]         next_term_data;
  logic                         next_term_clk;
  logic                         next_ref_frame;
  logic                         next_err_pulse;
  logic                         search_pulse;
  logic                         byte_done;
  logic                         frame_wrap;
  logic [BYTE_BITS-1:0]         raw_byte;
  logic [BYTE_BITS-1:0]         descr_byte;

  always_comb begin
    // The frame search pulse takes effect on the release of the active-low input.
    search_pulse     = line_search_n && !search_n_d;
    next_search_n_d  = line_search_n;
    next_rx_state    = rx_state;
    next_line_bit    = line_bit;
    next_rx_delay    = rx_delay;
    next_descr_bit   = descr_bit;
    next_raw_bit     = raw_bit;
    next_scr         = scr;
    next_descr_shift = descr_shift;
    next_raw_shift   = raw_shift;
    next_bit_cnt     = bit_cnt;
    next_byte_cnt    = byte_cnt;
    next_bip_acc     = bip_acc;
    next_bip_prev    = bip_prev;
    next_bip_valid   = bip_valid;
    next_err_pend    = err_pend;
    next_term_data   = rx_terminal_data_o;
    next_term_clk    = rx_terminal_clock_o;
    next_ref_frame   = rx_reference_frame_o;
    next_err_pulse   = parity_error_pulse_o;
    byte_done        = (bit_cnt == LAST_BIT);
    frame_wrap       = byte_done && (byte_cnt == BYTE_CNT_W'(FRAME_BYTES - 1));
    raw_byte         = {raw_shift, raw_bit};
    descr_byte       = {descr_shift, descr_bit};
    if (line_ce) begin
      // An invalid differential pair keeps the last good level instead of guessing.
      if (line_true != line_comp) begin
        next_line_bit = line_true;
      end
      next_rx_delay = {rx_delay[RX_DELAY_STAGES-2:0], line_bit};
      next_raw_bit  = rx_delay[RX_DELAY_STAGES-1];
      // Deselected descrambling passes the static line level straight to the bus.
      next_descr_bit = rx_delay[RX_DELAY_STAGES-1];
      if (line_descr_sel) begin
        // The descrambler keeps running on static input, so loss gives scrambled noise.
        next_descr_bit = rx_delay[RX_DELAY_STAGES-1] ^ scr[6];
        next_scr       = {scr[5:0], scr[6] ^ scr[5]};
      end
      if (frame_wrap) begin
        next_scr = SCR_SEED;
      end
      next_descr_shift = {descr_shift[BYTE_BITS-3:0], descr_bit};
      next_raw_shift   = {raw_shift[BYTE_BITS-3:0], raw_bit};
      next_bit_cnt     = bit_cnt + 1'b1;
      if (byte_done) begin
        // The last bit joins the byte in the same edge that loads the bus.
        next_term_data = descr_byte;
        next_byte_cnt  = frame_wrap ? '0 : byte_cnt + 1'b1;
        next_ref_frame = (rx_state == RX_ALIGNED) && frame_wrap;
        // One error bit per byte slot leaves the queue, giving at most eight a frame.
        next_err_pulse = err_pend[MAX_ERR_PULSES-1];
        next_err_pend  = {err_pend[MAX_ERR_PULSES-2:0], 1'b0};
        next_bip_acc   = bip_acc ^ raw_byte;
        if (frame_wrap) begin
          next_bip_prev  = bip_acc ^ raw_byte;
          next_bip_acc   = '0;
          next_bip_valid = (rx_state == RX_ALIGNED);
        end
        if (byte_cnt == BYTE_CNT_W'(B1_BYTE_INDEX) && bip_valid && rx_state == RX_ALIGNED) begin
          next_err_pend = bip_prev ^ descr_byte;
        end
      end
      // Terminal clock falls exactly when new data is loaded, so both change on its falling edge.
      next_term_clk = next_bit_cnt[TERM_CLK_BIT];
      if (search_pulse) begin
        next_rx_state  = RX_ALIGNED;
        next_bit_cnt   = '0;
        next_byte_cnt  = '0;
        next_bip_acc   = '0;
        next_bip_valid = 1'b0;
        next_err_pend  = '0;
        next_scr       = SCR_SEED;
        next_term_clk  = 1'b0;
      end
      case (rx_state)
        RX_WAIT_SEARCH: begin
          next_ref_frame = 1'b0;
          next_err_pulse = 1'b0;
        end
        RX_ALIGNED: begin
        end
        default: begin
          next_rx_state = RX_WAIT_SEARCH;
        end
      endcase
    end
  end

  // Every receive output is a line-domain flop, so a dead line clock freezes them.
  always_ff @(posedge rx_line_clock_i or negedge line_reset_n) begin
    if (!line_reset_n) begin
      rx_state             <= RX_WAIT_SEARCH;
      line_bit             <= 1'b0;
      rx_delay             <= '0;
      descr_bit            <= 1'b0;
      raw_bit              <= 1'b0;
      scr                  <= SCR_SEED;
      descr_shift          <= '0;
      raw_shift            <= '0;
      bit_cnt              <= '0;
      byte_cnt             <= '0;
      bip_acc              <= '0;
      bip_prev             <= '0;
      bip_valid            <= 1'b0;
      err_pend             <= '0;
      search_n_d           <= 1'b1;
      rx_terminal_data_o   <= '0;
      rx_terminal_clock_o  <= 1'b0;
      rx_reference_frame_o <= 1'b0;
      parity_error_pulse_o <= 1'b0;
    end else begin
      rx_state             <= next_rx_state;
      line_bit             <= next_line_bit;
      rx_delay             <= next_rx_delay;
      descr_bit            <= next_descr_bit;
      raw_bit              <= next_raw_bit;
      scr                  <= next_scr;
      descr_shift          <= next_descr_shift;
      raw_shift            <= next_raw_shift;
      bit_cnt              <= next_bit_cnt;
      byte_cnt             <= next_byte_cnt;
      bip_acc              <= next_bip_acc;
      bip_prev             <= next_bip_prev;
      bip_valid            <= next_bip_valid;
      err_pend             <= next_err_pend;
      search_n_d           <= next_search_n_d;
      rx_terminal_data_o   <= next_term_data;
      rx_terminal_clock_o  <= next_term_clk;
      rx_reference_frame_o <= next_ref_frame;
      parity_error_pulse_o <= next_err_pulse;
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit side: the system clock stands in for the bit-rate clock.
  // ---------------------------------------------------------------------------
  logic                       sys_invert;
  logic                       fifo_valid;
  logic                       fifo_pop;
  logic [FIFO_WIDTH-1:0]      fifo_data;
  logic [BIT_CNT_W-1:0]       ref_div;
  logic [BIT_CNT_W-1:0]       next_ref_div;
  logic [BYTE_CNT_W-1:0]      tx_byte_cnt;
  logic [BYTE_CNT_W-1:0]      next_tx_byte_cnt;
  logic [BYTE_BITS-1:0]       tx_shift;
  logic [BYTE_BITS-1:0]       next_tx_shift;
  logic [TX_DELAY_STAGES-1:0] tx_delay;
  logic [TX_DELAY_STAGES-1:0] next_tx_delay;
  logic                       next_tx_true;
  logic                       next_ref_clk;
  logic                       next_tx_frame;

  sync_two_flop #(.RESET_VAL(1'b0)) u_sys_invert (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (tx_ref_edge_invert_i),
    .q_o       (sys_invert)
  );

  // The serializer drains only at byte slots, so a faster source fills the buffer and is stalled.
  stream_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (tx_terminal_valid_i),
    .in_ready_o  (tx_terminal_ready_o),
    .in_data_i   (tx_terminal_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  always_comb begin
    next_ref_div     = ref_div;
    next_tx_byte_cnt = tx_byte_cnt;
    next_tx_shift    = tx_shift;
    next_tx_delay    = tx_delay;
    next_tx_true     = tx_line_data_true_o;
    next_ref_clk     = tx_reference_clock_o;
    next_tx_frame    = tx_reference_frame_o;
    fifo_pop         = 1'b0;
    if (ce_i) begin
      // The divider resets to LAST_BIT, so it wraps to zero on the first edge after reset release, restarting the reference clock cleanly.
      next_ref_div  = ref_div + 1'b1;
      next_ref_clk  = (next_ref_div < REF_FALL_PHASE);
      next_tx_shift = {tx_shift[BYTE_BITS-2:0], 1'b0};
      if (next_ref_div == REF_RISE_PHASE) begin
        next_tx_byte_cnt = (tx_byte_cnt == BYTE_CNT_W'(FRAME_BYTES - 1)) ? '0 : tx_byte_cnt + 1'b1;
        // An empty buffer sends zeros rather than stalling the line.
        fifo_pop      = fifo_valid;
        next_tx_shift = fifo_valid ? fifo_data : '0;
      end
      if ((sys_invert && next_ref_div == REF_FALL_PHASE) || (!sys_invert && next_ref_div == REF_RISE_PHASE)) begin
        next_tx_frame = (next_tx_byte_cnt == '0);
      end
      next_tx_delay = {tx_delay[TX_DELAY_STAGES-2:0], tx_shift[BYTE_BITS-1]};
      next_tx_true  = tx_delay[TX_DELAY_STAGES-1];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_div              <= LAST_BIT;
      tx_byte_cnt          <= BYTE_CNT_W'(FRAME_BYTES - 1);
      tx_shift             <= '0;
      tx_delay             <= '0;
      tx_line_data_true_o  <= 1'b0;
      tx_line_data_comp_o  <= 1'b1;
      tx_reference_clock_o <= 1'b0;
      tx_reference_frame_o <= 1'b0;
    end else begin
      ref_div              <= next_ref_div;
      tx_byte_cnt          <= next_tx_byte_cnt;
      tx_shift             <= next_tx_shift;
      tx_delay             <= next_tx_delay;
      tx_line_data_true_o  <= next_tx_true;
      tx_line_data_comp_o  <= !next_tx_true;
      tx_reference_clock_o <= next_ref_clk;
      tx_reference_frame_o <= next_tx_frame;
    end
  end

endmodule

// >>> test/sts3_sync_monitor.sv
// Concurrent checks on the ports of the line frame synchronizer.
`timescale 1ns/1ps
module sts3_sync_monitor
  import sts3_sync_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 reset_n_i,
  input wire logic                 rx_line_clock_i,
  input wire logic                 rx_line_data_true_i,
  input wire logic                 descrambler_select_i,
  input wire logic                 tx_ref_edge_invert_i,
  input wire logic [BYTE_BITS-1:0] rx_terminal_data_o,
  input wire logic                 rx_terminal_clock_o,
  input wire logic                 rx_reference_frame_o,
  input wire logic                 parity_error_pulse_o,
  input wire logic                 tx_line_data_true_o,
  input wire logic                 tx_line_data_comp_o,
  input wire logic                 tx_reference_clock_o,
  input wire logic                 tx_reference_frame_o
);
  logic [5:0]  quiet;
  logic [3:0]  err_cnt;
  logic [54:0] hist;

  // Latency is checked only once every bit in flight was taken undescrambled.
  always_ff @(posedge rx_line_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quiet   <= 6'h00;
      err_cnt <= 4'h0;
      hist    <= '0;
    end else begin
      hist  <= {hist[53:0], rx_line_data_true_i};
      quiet <= descrambler_select_i ? 6'h00 : ((quiet == 6'h3f) ? quiet : quiet + 6'h01);
      if ($rose(rx_reference_frame_o))
        err_cnt <= 4'h0;
      else if ($fell(rx_terminal_clock_o) && parity_error_pulse_o && err_cnt != 4'hf)
        err_cnt <= err_cnt + 4'h1;
    end
  end

  a_comp_inverse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_line_data_comp_o == !tx_line_data_true_o) else $error("line complement is not the inverse");
  a_ref_clock_shape: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(tx_reference_clock_o) |-> tx_reference_clock_o [*4] ##1 !tx_reference_clock_o)
    else $error("reference clock high phase wrong");
  a_ref_frame_edge: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $changed(tx_reference_frame_o) |-> (tx_ref_edge_invert_i ? $fell(tx_reference_clock_o)
    : $rose(tx_reference_clock_o))) else $error("reference frame changed on wrong edge");
  a_ref_frame_width: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(tx_reference_frame_o) |-> tx_reference_frame_o [*8] ##1 !tx_reference_frame_o)
    else $error("reference frame width wrong");
  a_rx_latency: assert property (@(posedge rx_line_clock_i) disable iff (!reset_n_i)
    ($fell(rx_terminal_clock_o) && quiet == 6'h3f) |-> rx_terminal_data_o == hist[54:47])
    else $error("receive byte not at fixed latency");
  a_rx_data_fall: assert property (@(posedge rx_line_clock_i) disable iff (!reset_n_i)
    $changed(rx_terminal_data_o) |-> $fell(rx_terminal_clock_o)) else $error("receive data moved off clock fall");
  a_rx_frame_fall: assert property (@(posedge rx_line_clock_i) disable iff (!reset_n_i)
    $changed(rx_reference_frame_o) |-> $fell(rx_terminal_clock_o)) else $error("receive frame moved off fall");
  a_parity_fall: assert property (@(posedge rx_line_clock_i) disable iff (!reset_n_i)
    $changed(parity_error_pulse_o) |-> $fell(rx_terminal_clock_o)) else $error("parity pulse off clock fall");
  a_parity_limit: assert property (@(posedge rx_line_clock_i) disable iff (!reset_n_i)
    err_cnt <= 4'h8) else $error("more than eight parity pulses in a frame");

  c_parity: cover property (@(posedge rx_line_clock_i) disable iff (!reset_n_i) $rose(parity_error_pulse_o));
  c_rx_frame: cover property (@(posedge rx_line_clock_i) disable iff (!reset_n_i) $rose(rx_reference_frame_o));
  c_tx_inv: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(tx_reference_frame_o) && tx_ref_edge_invert_i);
endmodule

bind sts3_sync_init_and_los_handling sts3_sync_monitor u_sts3_sync_monitor (.clk_i, .reset_n_i, .rx_line_clock_i,
  .rx_line_data_true_i, .descrambler_select_i, .tx_ref_edge_invert_i, .rx_terminal_data_o, .rx_terminal_clock_o,
  .rx_reference_frame_o, .parity_error_pulse_o, .tx_line_data_true_o, .tx_line_data_comp_o, .tx_reference_clock_o,
  .tx_reference_frame_o);

// >>> test/line_partner.sv
// Line side stand-in: a stoppable 6 ns line clock and complementary line data.
`timescale 1ns/1ps
module line_partner (
  input  wire logic run_i,
  input  wire logic pattern_i,
  input  wire logic level_i,
  output logic      line_clock_o,
  output logic      data_true_o,
  output logic      data_comp_o
);
  logic [15:0] pattern;

  // The clock holds its level while stopped, as a dead receiver would.
  initial begin
    line_clock_o = 1'b0;
    pattern = 16'hb38e;
    #1.7;
    forever begin
      #3;
      if (run_i)
        line_clock_o = ~line_clock_o;
    end
  end
  always @(negedge line_clock_o)
    pattern <= {pattern[14:0], pattern[15]};
  assign data_true_o = pattern_i ? pattern[15] : level_i;
  assign data_comp_o = ~data_true_o;
endmodule

// >>> test/sts3_sync_init_and_los_handling_tb.sv
// Self-checking bench for the line frame synchronizer.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module sts3_sync_init_and_los_handling_tb import sts3_sync_pkg::*;;
  localparam logic [7:0] TX_BYTE = 8'ha5;
  logic       clk_i, reset_n_i, ce_i, run, pat_en, level, line_clk, line_t, line_c, seen, held_clk;
  logic       descrambler_select_i, frame_search_trigger_n_i, tx_ref_edge_invert_i, tx_terminal_valid_i;
  logic [7:0] tx_terminal_data_i, rx_terminal_data_o, held;
  logic       tx_terminal_ready_o, rx_terminal_clock_o, rx_reference_frame_o, parity_error_pulse_o;
  logic       tx_line_data_true_o, tx_line_data_comp_o, tx_reference_clock_o, tx_reference_frame_o;
  int         n_errors, samples_checked;

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  line_partner u_line_partner (.run_i(run), .pattern_i(pat_en), .level_i(level), .line_clock_o(line_clk),
    .data_true_o(line_t), .data_comp_o(line_c));
  sts3_sync_init_and_los_handling u_sts3_sync_init_and_los_handling (.clk_i, .reset_n_i, .ce_i,
    .rx_line_clock_i(line_clk), .rx_line_data_true_i(line_t), .rx_line_data_comp_i(line_c), .descrambler_select_i,
    .frame_search_trigger_n_i, .tx_ref_edge_invert_i, .tx_terminal_data_i, .tx_terminal_valid_i,
    .tx_terminal_ready_o, .rx_terminal_data_o, .rx_terminal_clock_o, .rx_reference_frame_o, .parity_error_pulse_o,
    .tx_line_data_true_o, .tx_line_data_comp_o, .tx_reference_clock_o, .tx_reference_frame_o);

  task automatic clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  wire [4:0] watch = {parity_error_pulse_o, tx_reference_clock_o, tx_terminal_ready_o, rx_reference_frame_o,
    tx_reference_frame_o};

  task automatic wait_sig(input int w, input logic v, input int lim);
    for (int i = 0; i < lim && watch[w] !== v; i++)
      @(negedge clk_i);
    if (watch[w] !== v) begin
      n_errors++;
      $display("timeout waiting on output %0d", w);
      report_and_stop();
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    int i;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    run = 1'b1;
    pat_en = 1'b0;
    level = 1'b0;
    descrambler_select_i = 1'b0;
    frame_search_trigger_n_i = 1'b1;
    tx_ref_edge_invert_i = 1'b0;
    tx_terminal_data_i = 8'h00;
    tx_terminal_valid_i = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    clks(19);
    `CHK(rx_terminal_data_o, 8'h00);
    `CHK(tx_line_data_comp_o, 1'b1);
    `CHK(tx_terminal_ready_o, 1'b1);
    `CHK(tx_reference_clock_o, 1'b0);
    clks(1);
    reset_n_i = 1'b1;
    clks(1);
    `CHK(tx_reference_clock_o, 1'b1);
    `CHK(tx_reference_frame_o, 1'b1);
    $display("test reset finished");
    // One byte, popped at the next reference rise.
    wait_sig(3, 1'b0, 10);
    wait_sig(3, 1'b1, 10);
    tx_terminal_data_i = TX_BYTE;
    tx_terminal_valid_i = 1'b1;
    clks(1);
    tx_terminal_valid_i = 1'b0;
    wait_sig(3, 1'b0, 10);
    wait_sig(3, 1'b1, 10);
    clks(43);
    `CHK(tx_line_data_true_o, 1'b0);
    for (i = 7; i >= 0; i--) begin
      clks(1);
      `CHK(tx_line_data_true_o, TX_BYTE[i]);
    end
    $display("test transmit latency finished");
    tx_terminal_valid_i = 1'b1;
    for (i = 0; i < 20 && tx_terminal_ready_o === 1'b1; i++) begin
      tx_terminal_data_i = i[7:0];
      clks(1);
    end
    tx_terminal_valid_i = 1'b0;
    `CHK(i >= 8 && i <= 9, 1'b1);
    wait_sig(2, 1'b1, 20);
    $display("test buffer fill finished");
    tx_ref_edge_invert_i = 1'b1;
    wait_sig(0, 1'b1, 20000);
    `CHK(tx_reference_clock_o, 1'b0);
    $display("test inversion finished");
    level = 1'b1;
    clks(25);
    `CHK(rx_terminal_data_o, 8'hff);
    level = 1'b0;
    clks(25);
    `CHK(rx_terminal_data_o, 8'h00);
    descrambler_select_i = 1'b1;
    clks(25);
    seen = 1'b0;
    for (i = 0; i < 8; i++) begin
      clks(3);
      if (rx_terminal_data_o !== 8'h00 && rx_terminal_data_o !== 8'hff)
        seen = 1'b1;
    end
    `CHK(seen, 1'b1);
    $display("test static line finished");
    run = 1'b0;
    clks(2);
    held = rx_terminal_data_o;
    held_clk = rx_terminal_clock_o;
    level = 1'b1;
    descrambler_select_i = 1'b0;
    clks(30);
    `CHK(rx_terminal_data_o, held);
    `CHK(rx_terminal_clock_o, held_clk);
    run = 1'b1;
    $display("test line clock loss finished");
    pat_en = 1'b1;
    frame_search_trigger_n_i = 1'b0;
    clks(6);
    frame_search_trigger_n_i = 1'b1;
    wait_sig(1, 1'b1, 12000);
    `CHK(rx_reference_frame_o, 1'b1);
    wait_sig(4, 1'b1, 12000);
    `CHK(parity_error_pulse_o, 1'b1);
    $display("test search and parity finished");
    report_and_stop();
  end
endmodule
